// *** pkg/arpm_pkg.sv ***
// arpm_pkg: constants and carrier types for the receiver pin-function mux
// assumes a single core_clk domain at 200 MHz and synchronous straps
package arpm_pkg;

    // ----------------------------------------------------------------
    // control modes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ARPM_MODE_PAR,
        ARPM_MODE_SER4,
        ARPM_MODE_I2C
    } arpm_mode_t;

    // ----------------------------------------------------------------
    // master clock ratios and rate threshold
    // ----------------------------------------------------------------
    localparam logic [1:0] ARPM_RATIO_64    = 2'h0;
    localparam logic [1:0] ARPM_RATIO_128   = 2'h1;
    localparam logic [1:0] ARPM_RATIO_256   = 2'h2;
    localparam logic [1:0] ARPM_RATIO_512   = 2'h3;
    localparam int         ARPM_CLK_MHZ     = 200;
    localparam int         ARPM_I2C_MAX_KHZ = 400;
    localparam int         ARPM_HR_LO_KHZ   = 54;
    localparam int         ARPM_HR_HI_KHZ   = 64;
    localparam logic [0:0] ARPM_HRD_RST     = 1'h0;
    localparam logic [1:0] ARPM_DIV_RST     = 2'h0;
    localparam int         ARPM_NUM_RX      = 6;
    localparam int         ARPM_PAR_RX      = 2;
    localparam int         ARPM_DIVW        = 9;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic pin27;
        logic pin28;
        logic pin29_i;
        logic pin30_i;
    } arpm_hpin_in_t;

    typedef struct packed {
        logic pin29_o;
        logic pin29_oe;
        logic pin30_o;
        logic pin30_oe;
    } arpm_hpin_out_t;

    typedef struct packed {
        logic       chip_sel_n;
        logic       ctrl_clk;
        logic       ctrl_din;
        logic       scl;
        logic       sda_i;
        logic [1:0] dev_addr;
        logic [1:0] out_clk_sel;
        logic [1:0] mclk_mode;
    } arpm_hfun_t;

endpackage

// *** rtl/arpm_mclk_div.sv ***
// arpm_mclk_div: derives one master clock from a 512fs base tick
// assumes base_512fs toggles at 512fs synchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
module arpm_mclk_div (
    input  wire logic         core_clk,
    input  wire logic         srst,
    input  wire logic         base_512fs,
    input  wire logic [1:0]   ratio,
    output logic              mclk
);
    import arpm_pkg::*;

    logic [2:0] cnt_q;
    logic       base_d1_q;

    // count base rising edges; bit taps divide by 2,4,8
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnt_q     <= 3'h0;
            base_d1_q <= 1'h0;
        end else begin
            base_d1_q <= base_512fs;
            if (base_512fs && !base_d1_q) begin
                cnt_q <= cnt_q + 3'h1;
            end
        end
    end

    // ratio tap selection
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mclk <= 1'h0;
        end else begin
            unique case (ratio)
                ARPM_RATIO_512: mclk <= base_512fs;
                ARPM_RATIO_256: mclk <= cnt_q[0];
                ARPM_RATIO_128: mclk <= cnt_q[1];
                ARPM_RATIO_64:  mclk <= cnt_q[2];
            endcase
        end
    end
endmodule
`default_nettype wire

// *** rtl/arpm_pin_mux.sv ***
// arpm_pin_mux: strap decode and pin-function routing for the audio receiver
// assumes core signals and straps are synchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
// How it works
// - power_down_n low holds every register in reset, registered outputs quiet.
// - parallel_serial_strap low gives serial control, high gives parallel.
// - in serial control, i2c strap low picks 4-wire, high picks I2C.
// - 4-wire mode maps host pins to chip select, clock, data in, data out.
// - I2C mode maps host pins to SCL, bidirectional SDA, two address straps.
// - irq_out_b carries interrupt 1, or user bits, or channel-status bits.
// - mclk_out_b carries master clock 2 or block start per bit_output_ctrl.
// - two master clocks, each selectable 64, 128, 256 or 512 fs.
// - parallel mode with the 24.576 MHz crystal high_rate_detect low at 54 kHz or less, high at 64.
// - shared pin gives validity in parallel mode, through data in serial.
// - format selects in parallel mode, receiver inputs 2 to 4 in serial.
// - input channel select in parallel mode, receiver input in serial.
// - parallel mode host pins act as output clock and mclk mode straps.
// - serial mode picks one of six receivers; one through output exists.
// - parallel mode offers two receivers, serial mode six.
module arpm_pin_mux (
    input  wire logic                     core_clk,
    input  wire logic                     srst,
    input  wire logic                     power_down_n,
    input  wire logic                     parallel_serial_strap,
    input  wire logic                     i2c_sel_strap,
    input  wire arpm_pkg::arpm_hpin_in_t  host_pin_in,
    output arpm_pkg::arpm_hpin_out_t      host_pin_out,
    output arpm_pkg::arpm_hfun_t          host_fun,
    output arpm_pkg::arpm_mode_t          ctrl_mode,
    input  wire logic                     host_ctrl_dout,
    input  wire logic                     sda_o_low,
    input  wire logic                     rx_in_1,
    input  wire logic                     pin12_in,
    input  wire logic                     pin13_in,
    input  wire logic                     pin14_in,
    input  wire logic                     rx_in_5,
    input  wire logic                     pin16_in,
    input  wire logic [2:0]               ser_rx_sel,
    output logic                          rx_selected,
    output logic [2:0]                    fmt_sel,
    output logic                          input_chan_sel,
    input  wire logic                     bit_output_ctrl,
    input  wire logic                     user_chstat_select,
    input  wire logic                     irq0_core,
    input  wire logic                     irq1_core,
    input  wire logic                     user_bit,
    input  wire logic                     chstat_bit,
    input  wire logic                     block_start,
    input  wire logic                     base_512fs,
    input  wire logic [1:0]               ser_ratio_a,
    input  wire logic [1:0]               ser_ratio_b,
    input  wire logic                     validity_flag,
    input  wire logic                     through_data,
    input  wire logic                     crystal_is_24m576,
    input  wire logic [8:0]               fs_khz,
    output logic                          irq_out_a,
    output logic                          irq_out_b,
    output logic                          mclk_out_a,
    output logic                          mclk_out_b,
    output logic                          validity_tx_out,
    output logic                          high_rate_detect,
    output logic                          high_rate_oe
);
    import arpm_pkg::*;

    // ----------------------------------------------------------------
    // reset and mode decode
    // ----------------------------------------------------------------
    logic       rst_all;
    logic       is_par;
    logic [1:0] ratio_a;
    logic [1:0] ratio_b;
    logic       mclk_a_raw;
    logic       mclk_b_raw;

    // power-down acts as a reset on top of srst
    assign rst_all = srst | ~power_down_n;

    function automatic arpm_mode_t decode_mode(input logic ps, input logic i2c);
        if (ps) begin
            decode_mode = ARPM_MODE_PAR;
        end else if (i2c) begin
            decode_mode = ARPM_MODE_I2C;
        end else begin
            decode_mode = ARPM_MODE_SER4;
        end
    endfunction

    assign ctrl_mode = rst_all ? ARPM_MODE_PAR
                     : decode_mode(parallel_serial_strap, i2c_sel_strap);
    assign is_par    = (ctrl_mode == ARPM_MODE_PAR);

    // ----------------------------------------------------------------
    // host pin routing
    // ----------------------------------------------------------------
    // each mode gives the four shared host pins their own meaning
    always_comb begin
        host_fun                = '0;
        host_fun.chip_sel_n     = 1'h1;
        host_pin_out            = '0;
        unique case (ctrl_mode)
            ARPM_MODE_SER4: begin
                host_fun.chip_sel_n   = host_pin_in.pin27;
                host_fun.ctrl_clk     = host_pin_in.pin28;
                host_fun.ctrl_din     = host_pin_in.pin29_i;
                host_pin_out.pin30_o  = host_ctrl_dout;
                host_pin_out.pin30_oe = 1'h1;
            end
            ARPM_MODE_I2C: begin
                host_fun.dev_addr     = {host_pin_in.pin30_i, host_pin_in.pin27};
                host_fun.scl          = host_pin_in.pin28;
                host_fun.sda_i        = host_pin_in.pin29_i;
                host_pin_out.pin29_o  = 1'h0;                 // open drain
                host_pin_out.pin29_oe = sda_o_low;
            end
            ARPM_MODE_PAR: begin
                host_fun.out_clk_sel  = {host_pin_in.pin28, host_pin_in.pin27};
                host_fun.mclk_mode    = {host_pin_in.pin29_i, host_pin_in.pin30_i};
            end
            default: begin
                host_fun.chip_sel_n   = 1'h1;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // receiver and format pins
    // ----------------------------------------------------------------
    // parallel: pins 12-14 are format, pin 16 is channel select
    assign fmt_sel        = is_par ? {pin14_in, pin13_in, pin12_in} : 3'h0;
    assign input_chan_sel = is_par ? pin16_in : 1'h0;

    // receiver selection, six in serial, two in parallel
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            rx_selected <= 1'h0;
        end else if (is_par) begin
            rx_selected <= pin16_in ? rx_in_5 : rx_in_1;
        end else begin
            unique case (ser_rx_sel)
                3'h0:    rx_selected <= rx_in_1;
                3'h1:    rx_selected <= pin12_in;
                3'h2:    rx_selected <= pin13_in;
                3'h3:    rx_selected <= pin14_in;
                3'h4:    rx_selected <= rx_in_5;
                3'h5:    rx_selected <= pin16_in;
                default: rx_selected <= 1'h0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // master clocks
    // ----------------------------------------------------------------
    // parallel straps choose both ratios; serial uses control bits
    assign ratio_a = is_par ? host_fun.mclk_mode : ser_ratio_a;
    assign ratio_b = is_par ? host_fun.mclk_mode : ser_ratio_b;

    arpm_mclk_div u_div_a (
        .core_clk   (core_clk),
        .srst       (rst_all),
        .base_512fs (base_512fs),
        .ratio      (ratio_a),
        .mclk       (mclk_a_raw)
    );

    arpm_mclk_div u_div_b (
        .core_clk   (core_clk),
        .srst       (rst_all),
        .base_512fs (base_512fs),
        .ratio      (ratio_b),
        .mclk       (mclk_b_raw)
    );

    // ----------------------------------------------------------------
    // output pin functions
    // ----------------------------------------------------------------
    // each output but high_rate_oe registered; bit_output_ctrl switches irq_out_b and mclk_out_b together
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            irq_out_a <= 1'h0;
            irq_out_b <= 1'h0;
        end else begin
            irq_out_a <= irq0_core;
            if (!bit_output_ctrl) begin
                irq_out_b <= irq1_core;
            end else begin
                irq_out_b <= user_chstat_select ? chstat_bit : user_bit;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            mclk_out_a <= 1'h0;
            mclk_out_b <= 1'h0;
        end else begin
            mclk_out_a <= mclk_a_raw;
            mclk_out_b <= bit_output_ctrl ? block_start : mclk_b_raw;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            validity_tx_out <= 1'h0;
        end else begin
            validity_tx_out <= is_par ? validity_flag : through_data;
        end
    end

    // rate detect holds between thresholds; only with the 24.576 MHz crystal
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            high_rate_detect <= ARPM_HRD_RST;
        end else if (is_par && crystal_is_24m576) begin
            if (fs_khz <= 9'(ARPM_HR_LO_KHZ)) begin
                high_rate_detect <= 1'h0;
            end else if (fs_khz >= 9'(ARPM_HR_HI_KHZ)) begin
                high_rate_detect <= 1'h1;
            end
        end else begin
            high_rate_detect <= 1'h0;
        end
    end

    // pin 19 drives only in parallel mode, else it is the i2c strap input
    assign high_rate_oe = is_par;
endmodule
`default_nettype wire

// *** tb/arpm_host_model.sv ***
// arpm_host_model: host and strap side of the shared control pins
// assumes the bench supplies pin levels and the i2c mode flag
`timescale 1ns/10ps
`default_nettype none
module arpm_host_model
    import arpm_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           i2c_mode,
    input  wire logic [3:0]     drv,
    input  wire arpm_hpin_out_t pin_out,
    output arpm_hpin_in_t       pin_in
);
    logic [7:0] cnt_q = 8'h00;
    logic       scl_q = 1'h1;
    logic       sda_w;
    // host clock pin; in i2c it moves at most once per 250 cycles
    always @(negedge core_clk) begin
        cnt_q <= (cnt_q >= 8'hF9) ? 8'h00 : cnt_q + 8'h01;
        if (!i2c_mode || cnt_q == 8'h00) begin
            scl_q <= drv[1];
        end
    end
    // data line is open drain with pull-up; pin30 follows whoever drives it
    assign sda_w  = drv[2] & ~(pin_out.pin29_oe & ~pin_out.pin29_o);
    assign pin_in = {drv[0], scl_q, sda_w, pin_out.pin30_oe ? pin_out.pin30_o : drv[3]};
endmodule
`default_nettype wire

// *** tb/arpm_pin_mux_checker.sv ***
// arpm_pin_mux_checker: port-level properties of the receiver pin mux
// assumes one core_clk domain; bound into every arpm_pin_mux
`timescale 1ns/10ps
`default_nettype none
module arpm_pin_mux_checker
    import arpm_pkg::*;
(
    input wire logic core_clk, srst, power_down_n, parallel_serial_strap,
    input wire logic i2c_sel_strap, host_ctrl_dout, sda_o_low, pin12_in,
    input wire logic pin13_in, pin14_in, pin16_in, input_chan_sel,
    input wire logic bit_output_ctrl, user_chstat_select, irq1_core,
    input wire logic user_bit, chstat_bit, block_start, validity_flag,
    input wire logic through_data, irq_out_a, irq_out_b, mclk_out_b,
    input wire logic validity_tx_out, high_rate_detect, rx_selected,
    input wire logic [2:0]     fmt_sel,
    input wire arpm_hpin_in_t  host_pin_in,
    input wire arpm_hpin_out_t host_pin_out,
    input wire arpm_hfun_t     host_fun,
    input wire arpm_mode_t     ctrl_mode
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    pdn_quiet_a: assert property (disable iff (srst) !power_down_n |=>
        {irq_out_a, irq_out_b, mclk_out_b, validity_tx_out, high_rate_detect,
         rx_selected} == 6'h00) else $error("outputs live in power-down");
    mode_sel_a: assert property (power_down_n |-> ctrl_mode ==
        (parallel_serial_strap ? ARPM_MODE_PAR : i2c_sel_strap ? ARPM_MODE_I2C :
         ARPM_MODE_SER4)) else $error("wrong control mode");
    four_wire_a: assert property (ctrl_mode == ARPM_MODE_SER4 |->
        host_fun.chip_sel_n == host_pin_in.pin27 && host_fun.ctrl_clk == host_pin_in.pin28
        && host_fun.ctrl_din == host_pin_in.pin29_i && host_pin_out.pin30_oe
        && host_pin_out.pin30_o == host_ctrl_dout) else $error("4-wire pin map");
    i2c_pins_a: assert property (ctrl_mode == ARPM_MODE_I2C |->
        host_fun.scl == host_pin_in.pin28 && host_fun.sda_i == host_pin_in.pin29_i
        && host_fun.dev_addr == {host_pin_in.pin30_i, host_pin_in.pin27}
        && host_pin_out.pin29_oe == sda_o_low && !host_pin_out.pin29_o
        && !host_pin_out.pin30_oe) else $error("i2c pin map");
    irqb_route_a: assert property (power_down_n |=> irq_out_b ==
        ($past(bit_output_ctrl) ? ($past(user_chstat_select) ? $past(chstat_bit)
         : $past(user_bit)) : $past(irq1_core))) else $error("irq b routing");
    mclkb_route_a: assert property (power_down_n && bit_output_ctrl |=>
        mclk_out_b == $past(block_start)) else $error("block start routing");
    valid_route_a: assert property (power_down_n |=> validity_tx_out ==
        ($past(parallel_serial_strap) ? $past(validity_flag) : $past(through_data)))
        else $error("validity pin routing");
    par_pins_a: assert property (power_down_n && ctrl_mode == ARPM_MODE_PAR |->
        fmt_sel == {pin14_in, pin13_in, pin12_in} && input_chan_sel == pin16_in
        && host_fun.out_clk_sel == {host_pin_in.pin28, host_pin_in.pin27}
        && host_fun.mclk_mode == {host_pin_in.pin29_i, host_pin_in.pin30_i})
        else $error("parallel strap map");

    // main scenarios reached
    cover property (ctrl_mode == ARPM_MODE_I2C && sda_o_low);
    cover property (ctrl_mode == ARPM_MODE_SER4 && host_ctrl_dout);
    cover property (power_down_n && bit_output_ctrl && user_chstat_select);
endmodule
bind arpm_pin_mux arpm_pin_mux_checker arpm_pin_mux_checker_inst (.*);
`default_nettype wire

// *** tb/testbench.sv ***
// testbench: random traffic through the pin mux plus clock ratio checks
// assumes the checker is bound and the host model sits on the shared pins
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
    $display("Error %0t: got %h exp %h", $time, a, e); end end
module testbench;
    import arpm_pkg::*;
    logic core_clk, srst, power_down_n, parallel_serial_strap, i2c_sel_strap;
    logic host_ctrl_dout, sda_o_low, rx_in_1, pin12_in, pin13_in, pin14_in;
    logic rx_in_5, pin16_in, bit_output_ctrl, user_chstat_select, irq0_core;
    logic irq1_core, user_bit, chstat_bit, block_start;
    logic base_512fs = 1'b0;
    logic hrd_exp = 1'b0;
    logic validity_flag, through_data, crystal_is_24m576, rx_selected;
    logic input_chan_sel, irq_out_a, irq_out_b, mclk_out_a, mclk_out_b;
    logic validity_tx_out, high_rate_detect, high_rate_oe;
    logic [1:0]     ser_ratio_a, ser_ratio_b;
    logic [2:0]     ser_rx_sel, fmt_sel;
    logic [3:0]     drv;
    logic [8:0]     fs_khz;
    logic [8:0]     fs_tab [7] = '{9'h020, 9'h030, 9'h036, 9'h03C, 9'h040, 9'h060, 9'h0C0};
    arpm_hpin_in_t  host_pin_in;
    arpm_hpin_out_t host_pin_out;
    arpm_hfun_t     host_fun;
    arpm_mode_t     ctrl_mode;
    int             num_errors = 0;
    int             checked = 0;
    typedef struct packed { logic [12:0] e; logic [12:0] m; } arpm_note_t;
    arpm_note_t     q[$];

    arpm_pin_mux arpm_pin_mux_inst (.*);
    arpm_host_model arpm_host_model_inst (.core_clk, .i2c_mode(ctrl_mode == ARPM_MODE_I2C),
        .drv, .pin_out(host_pin_out), .pin_in(host_pin_in));

    // ------------------------------------------------------------
    // clock, base tick, verdict and watchdog
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(negedge core_clk) base_512fs <= ~base_512fs;
    task automatic results();
        if (num_errors == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        results();
    end

    // ------------------------------------------------------------
    // expectations and monitor
    // ------------------------------------------------------------
    function automatic arpm_note_t expect_now();
        arpm_note_t n;
        logic [7:0] rxs;
        rxs = {2'h0, pin16_in, rx_in_5, pin14_in, pin13_in, pin12_in, rx_in_1};
        n.e[12:11] = parallel_serial_strap ? ARPM_MODE_PAR
                   : i2c_sel_strap ? ARPM_MODE_I2C : ARPM_MODE_SER4;
        n.e[10:6] = parallel_serial_strap ? {1'b1, pin16_in, pin14_in, pin13_in, pin12_in}
                  : 5'h00;
        // between the two thresholds the detector keeps its last level
        if (fs_khz > 9'(ARPM_HR_LO_KHZ) && fs_khz < 9'(ARPM_HR_HI_KHZ)) begin
            n.e[5] = parallel_serial_strap && crystal_is_24m576 && hrd_exp;
        end else begin
            n.e[5] = parallel_serial_strap && crystal_is_24m576
                     && fs_khz >= 9'(ARPM_HR_HI_KHZ);
        end
        n.e[4] = parallel_serial_strap ? (pin16_in ? rx_in_5 : rx_in_1) : rxs[ser_rx_sel];
        n.e[3] = parallel_serial_strap ? validity_flag : through_data;
        n.e[2:0] = {irq0_core, bit_output_ctrl ? (user_chstat_select ? chstat_bit
                   : user_bit) : irq1_core, block_start};
        n.m = bit_output_ctrl ? 13'h1FFF : 13'h1FFE;
        // power-down reads as parallel mode with every registered output at zero
        if (!power_down_n) begin
            n.e = {ARPM_MODE_PAR, 1'b1, pin16_in, pin14_in, pin13_in, pin12_in, 6'h00};
            n.m = 13'h1FFF;
        end
        hrd_exp = n.e[5];
        return n;
    endfunction
    // one edge after each note the outputs are compared with it
    initial begin
        arpm_note_t  n;
        logic [12:0] act;
        forever begin
            @(posedge core_clk);
            #1;
            if (q.size() > 0) begin
                n = q.pop_front();
                act = {ctrl_mode, high_rate_oe, input_chan_sel, fmt_sel, high_rate_detect,
                       rx_selected, validity_tx_out, irq_out_a, irq_out_b, mclk_out_b};
                `CHK(act & n.m, n.e & n.m)
            end
        end
    end

    // cycles between two rising edges of a master clock
    task automatic period(input logic pick_b, input logic [6:0] exp);
        logic       p;
        logic       s;
        logic [6:0] n;
        int         hits;
        s = pick_b ? mclk_out_b : mclk_out_a;
        p = s;
        n = 7'h00;
        hits = 0;
        for (int k = 0; k < 100 && hits < 2; k++) begin
            @(negedge core_clk);
            s = pick_b ? mclk_out_b : mclk_out_a;
            if (hits == 1) n++;
            if (s && !p) hits++;
            p = s;
        end
        `CHK(n, exp)
        if (hits < 2) begin
            num_errors++;
            results();
        end
    endtask

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        {parallel_serial_strap, i2c_sel_strap, host_ctrl_dout, sda_o_low, rx_in_1,
         pin12_in, pin13_in, pin14_in, rx_in_5, pin16_in, bit_output_ctrl,
         user_chstat_select, irq0_core, irq1_core, user_bit, chstat_bit, block_start,
         validity_flag, through_data, crystal_is_24m576, drv} = 24'h000000;
        {srst, power_down_n, ser_ratio_a, ser_ratio_b} = 6'h30;
        {ser_rx_sel, fs_khz} = 12'h030;
        void'($urandom(32'h86d7));
        repeat (6) @(negedge core_clk);
        srst = 1'b0;
        // random pins, straps, routing bits and power-down pulses
        repeat (3000) begin
            @(negedge core_clk);
            {parallel_serial_strap, i2c_sel_strap, host_ctrl_dout, sda_o_low, rx_in_1,
             pin12_in, pin13_in, pin14_in, rx_in_5, pin16_in, bit_output_ctrl,
             user_chstat_select, irq0_core, irq1_core, user_bit, chstat_bit, block_start,
             validity_flag, through_data, crystal_is_24m576, drv} = 24'($urandom);
            ser_rx_sel = 3'($urandom_range(7));
            fs_khz = fs_tab[$urandom_range(6)];
            power_down_n = ($urandom_range(15) != 0);
            #1;
            q.push_back(expect_now());
        end
        // both master clocks over every ratio, serial bits then parallel straps
        @(negedge core_clk);
        {power_down_n, parallel_serial_strap, bit_output_ctrl} = 3'h4;
        for (int r = 0; r < 8; r++) begin
            parallel_serial_strap = r[2];
            drv[3:2] = {r[0], r[1]};
            ser_ratio_a = 2'(r);
            ser_ratio_b = 2'(3 - r);
            repeat (40) @(negedge core_clk);
            period(1'b0, 7'(16 >> r[1:0]));
            period(1'b1, r[2] ? 7'(16 >> r[1:0]) : 7'(2 << r[1:0]));
        end
        results();
    end
endmodule
`default_nettype wire
